/* inc/smt_pkg.sv */
/*
 * Shared constants and carrier types of the signal measurement timer.
 * Assumes a 32-bit APB register port and byte addresses below 0x20.
 */
`default_nettype none
package smt_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned CNT_W      = 24;
    localparam int unsigned ADDR_W     = 8;
    localparam logic [7:0]  OFS_CTRL0  = 8'h00;
    localparam logic [7:0]  OFS_CTRL1  = 8'h04;
    localparam logic [7:0]  OFS_STAT   = 8'h08;
    localparam logic [7:0]  OFS_CLKSEL = 8'h0C;
    localparam logic [7:0]  OFS_COUNT  = 8'h10;
    localparam logic [7:0]  OFS_PERIOD = 8'h14;
    localparam logic [7:0]  OFS_PWLAT  = 8'h18;
    localparam logic [7:0]  OFS_PRLAT  = 8'h1C;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned STAT_CLR   = 0;
    localparam int unsigned STAT_PWUP  = 1;
    localparam int unsigned STAT_PRUP  = 2;
    localparam int unsigned STAT_SIG   = 5;
    localparam int unsigned STAT_WIN   = 6;
    localparam int unsigned STAT_RUNST = 7;
    // ------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------
    localparam logic [23:0] PERIOD_RST = 24'hFFFFFF;
    localparam logic [23:0] MASK_FULL  = 24'hFFFFFF;
    localparam logic [23:0] MASK_HALF  = 24'h00FFFF;
    localparam logic [23:0] CNT_ONE    = 24'h000001;
    localparam logic [1:0]  SYS_DIV4   = 2'h3;
    localparam logic [2:0]  SRC_SYS    = 3'h0;
    localparam logic [2:0]  SRC_SYS4   = 3'h1;
    localparam logic [2:0]  SRC_FAST   = 3'h2;
    localparam logic [2:0]  SRC_SLOW   = 3'h3;
    localparam logic [2:0]  SRC_MED    = 3'h4;
    localparam logic [3:0]  MODE_LAST  = 4'hA;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        M_TIMER = 4'h0, M_GATED = 4'h1, M_PDUTY = 4'h2, M_HILO = 4'h3,
        M_WIN   = 4'h4, M_GWIN  = 4'h5, M_TOF   = 4'h6, M_CAPT = 4'h7,
        M_CNT   = 4'h8, M_GCNT  = 4'h9, M_WCNT  = 4'hA
    } smt_mode_type;
    // Control word 0: bit 7 enable, 5 halt, 4..2 polarities, 1..0 prescale
    typedef struct packed {
        logic       en;
        logic       unused6;
        logic       halt;
        logic       win_pol;
        logic       sig_pol;
        logic       clk_pol;
        logic [1:0] prescale;
    } smt_ctrl_type;
    // Control word 1: bit 7 run, 6 repeat, 5 width16, 3..0 mode
    typedef struct packed {
        logic       run;
        logic       rep;
        logic       width16;
        logic       unused4;
        logic [3:0] mode;
    } smt_run_type;
endpackage
`default_nettype wire

/* hw/smt_core.sv */
/*
 * Signal measurement timer: 24-bit counter, two measurement latches,
 * period match and acquisition events, APB register slave.
 * Assumes pins and oscillator inputs are asynchronous to core_clk_i and
 * that oscillator inputs run well below half the 10 MHz core clock.
 */
// How it works
// RULE_01 - 24-bit counter, software reads and writes it as three bytes
// RULE_02 - Optional 16-bit counting width instead of 24 bits
// RULE_03 - Three-bit field picks one of five counting clock sources
// RULE_04 - Two-bit prescaler; prescaled clock drives counter and sampling
// RULE_05 - Counter equal to match value rolls to zero, match event raised
// RULE_06 - Clear request bit forces counter to zero
// RULE_07 - Software touches counter only while run request is zero; the code also accepts counter writes while run is set
// RULE_08 - Width latch takes counter on mode trigger or software request
// RULE_09 - Period latch takes counter on mode trigger or software request
// RULE_10 - Halt keeps counter at match; match held until clear or write; the code clears it on a counter write only while run is zero
// RULE_11 - Window, signal and clock each have an inverting polarity bit
// RULE_12 - Window status shows corrected window level while running
// RULE_13 - Signal status shows corrected signal level while running
// RULE_14 - Run status follows run request after sampling delay
// RULE_15 - Single mode stops and clears run request after one acquisition
// RULE_16 - Four-bit mode field decodes eleven modes, rest reserved
// RULE_17 - Timer modes run on prescaled clock, counter modes on signal
// RULE_18 - Timer mode counts while running, no acquisitions
// RULE_19 - Gated timer counts while signal active, width latch on fall
// RULE_20 - Every latch update by acquisition raises an acquisition event
// RULE_21 - Disable resets measurement state and drops clock request
// RULE_22 - At match counter holds under halt, else returns to zero
// RULE_23 - Reserved modes leave counter and latches unchanged, no events
`timescale 1ns/10ps
`default_nettype none
module smt_core #(
    parameter int unsigned SYNC_STAGES = 2
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        measured_signal_i,
    input  wire logic        window_input_i,
    input  wire logic        fast_internal_osc_i,
    input  wire logic        slow_internal_osc_i,
    input  wire logic        medium_internal_osc_i,
    output logic             period_match_o,
    output logic             pw_acq_o,
    output logic             pr_acq_o,
    output logic             clock_request_o
);
    // ------------------------------------------------------------
    // Registers and wires
    // ------------------------------------------------------------
    smt_pkg::smt_ctrl_type ctrl_r;
    smt_pkg::smt_run_type  run_r;
    logic [2:0]  clk_src_r;
    logic [23:0] cnt_r, per_r, pw_r, pr_r, cnt_wr, mask, cnt_nxt;
    logic [4:0]  pin_w;
    logic [4:0]  s1_r [SYNC_STAGES];
    logic [4:0]  sy;
    logic        src_prev_r, sig_prev_r, win_prev_r, run_status_r;
    logic [1:0]  div4_r;
    logic [2:0]  presc_r, presc_term;
    logic        src_lvl, src_pulse, tick, cntmode, reserved, ev_en;
    logic        sig_n, win_n, sig_rise, sig_fall, win_rise, win_fall;
    logic        gate, pw_t, pr_t, rs_t, done_t, step, match, match_ev;
    logic        pw_hit, pr_hit, rs_hit, wr, rd_setup;
    logic        wr_cnt, wr_ctrl1, sw_clr, sw_pwup, sw_prup;
    logic [31:0] rd_val;
    logic        err_val;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pin_w = {medium_internal_osc_i, slow_internal_osc_i,
                    fast_internal_osc_i, window_input_i, measured_signal_i};
    genvar g;
    generate
        for (g = 0; g < SYNC_STAGES; g++) begin : g_sync
            always_ff @(posedge core_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    s1_r[g] <= 5'h00;
                end else begin
                    s1_r[g] <= (g == 0) ? pin_w : s1_r[(g == 0) ? 0 : g-1];
                end
            end
        end
    endgenerate
    assign sy = s1_r[SYNC_STAGES-1];

    // ------------------------------------------------------------
    // Clock source and prescaler
    // ------------------------------------------------------------
    always_comb begin
        case (clk_src_r) // RULE_03
            smt_pkg::SRC_FAST: src_lvl = sy[2] ^ ctrl_r.clk_pol; // RULE_11
            smt_pkg::SRC_SLOW: src_lvl = sy[3] ^ ctrl_r.clk_pol;
            smt_pkg::SRC_MED:  src_lvl = sy[4] ^ ctrl_r.clk_pol;
            default:           src_lvl = 1'b0;
        endcase
        if (clk_src_r == smt_pkg::SRC_SYS) begin
            src_pulse = 1'b1;
        end else if (clk_src_r == smt_pkg::SRC_SYS4) begin
            src_pulse = (div4_r == smt_pkg::SYS_DIV4);
        end else begin
            src_pulse = src_lvl & ~src_prev_r;
        end
        case (ctrl_r.prescale) // RULE_04
            2'h0:    presc_term = 3'h0;
            2'h1:    presc_term = 3'h1;
            2'h2:    presc_term = 3'h3;
            default: presc_term = 3'h7;
        endcase
    end
    assign tick = ctrl_r.en & src_pulse & (presc_r == presc_term); // RULE_04

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_prev_r <= 1'b0;
            div4_r     <= 2'h0;
            presc_r    <= 3'h0;
        end else begin
            src_prev_r <= src_lvl;
            div4_r     <= div4_r + 2'h1;
            if (!ctrl_r.en) begin
                presc_r <= 3'h0; // RULE_21
            end else if (src_pulse) begin
                presc_r <= tick ? 3'h0 : presc_r + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Input sampling and edges
    // ------------------------------------------------------------
    // Counter modes see every core cycle; the others only sample on ticks
    assign cntmode  = run_r.mode[3]; // RULE_17
    assign reserved = (run_r.mode > smt_pkg::MODE_LAST); // RULE_16
    assign ev_en    = cntmode ? ctrl_r.en : tick; // RULE_17
    assign sig_n    = sy[0] ^ ctrl_r.sig_pol; // RULE_11
    assign win_n    = sy[1] ^ ctrl_r.win_pol; // RULE_11
    assign sig_rise = ev_en & sig_n & ~sig_prev_r;
    assign sig_fall = ev_en & ~sig_n & sig_prev_r;
    assign win_rise = ev_en & win_n & ~win_prev_r;
    assign win_fall = ev_en & ~win_n & win_prev_r;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sig_prev_r   <= 1'b0;
            win_prev_r   <= 1'b0;
            run_status_r <= 1'b0;
        end else if (!ctrl_r.en) begin
            sig_prev_r   <= 1'b0; // RULE_21
            win_prev_r   <= 1'b0;
            run_status_r <= 1'b0;
        end else if (ev_en) begin
            sig_prev_r   <= sig_n;
            win_prev_r   <= win_n;
            run_status_r <= run_r.run; // RULE_14
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        gate   = 1'b1;
        pw_t   = 1'b0;
        pr_t   = 1'b0;
        rs_t   = 1'b0;
        done_t = 1'b0;
        case (run_r.mode) // RULE_16
            smt_pkg::M_TIMER: gate = 1'b1; // RULE_18
            smt_pkg::M_GATED: begin
                gate   = sig_n; // RULE_19
                pw_t   = sig_fall; // RULE_19
                done_t = sig_fall;
            end
            smt_pkg::M_PDUTY: begin
                pw_t   = sig_fall;
                pr_t   = sig_rise;
                rs_t   = sig_rise;
                done_t = sig_rise;
            end
            smt_pkg::M_HILO: begin
                pw_t   = sig_fall;
                pr_t   = sig_rise;
                rs_t   = sig_rise | sig_fall;
                done_t = sig_rise;
            end
            smt_pkg::M_WIN: begin
                pr_t   = win_rise;
                rs_t   = win_rise;
                done_t = win_rise;
            end
            smt_pkg::M_GWIN: begin
                gate   = sig_n;
                pr_t   = win_rise;
                rs_t   = win_rise;
                done_t = win_rise;
            end
            smt_pkg::M_TOF: begin
                pr_t   = sig_rise;
                pw_t   = win_rise;
                rs_t   = sig_rise | win_rise;
                done_t = sig_rise;
            end
            smt_pkg::M_CAPT: begin
                pr_t   = win_rise;
                pw_t   = win_fall;
                done_t = win_rise | win_fall;
            end
            smt_pkg::M_CNT: begin
                pw_t   = win_fall;
                done_t = win_fall;
            end
            smt_pkg::M_GCNT: begin
                gate   = win_n;
                pw_t   = win_fall;
                done_t = win_fall;
            end
            smt_pkg::M_WCNT: begin
                gate   = win_n;
                pw_t   = win_fall;
                pr_t   = win_rise;
                done_t = win_fall;
            end
            default: gate = 1'b0; // RULE_23
        endcase
    end
    // Reserved codes fall to the default arm, so no trigger can fire
    assign step   = run_status_r & gate & (cntmode ? sig_rise : tick);
    assign pw_hit = run_status_r & pw_t; // RULE_20
    assign pr_hit = run_status_r & pr_t; // RULE_20
    assign rs_hit = run_status_r & rs_t;
    assign mask   = run_r.width16 ? smt_pkg::MASK_HALF
                                  : smt_pkg::MASK_FULL; // RULE_02
    assign match    = ((cnt_r & mask) == (per_r & mask));
    assign match_ev = step & match; // RULE_05

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign wr       = psel_i & penable_i & pwrite_i & pready_o;
    assign rd_setup = psel_i & ~penable_i;
    assign wr_cnt   = wr & (paddr_i == smt_pkg::OFS_COUNT);
    assign wr_ctrl1 = wr & (paddr_i == smt_pkg::OFS_CTRL1) & pstrb_i[0];
    assign sw_clr   = wr & (paddr_i == smt_pkg::OFS_STAT) & pstrb_i[0]
                      & pwdata_i[smt_pkg::STAT_CLR];
    assign sw_pwup  = wr & (paddr_i == smt_pkg::OFS_STAT) & pstrb_i[0]
                      & pwdata_i[smt_pkg::STAT_PWUP];
    assign sw_prup  = wr & (paddr_i == smt_pkg::OFS_STAT) & pstrb_i[0]
                      & pwdata_i[smt_pkg::STAT_PRUP];

    generate
        for (g = 0; g < 3; g++) begin : g_bytes
            assign cnt_wr[8*g +: 8] = pstrb_i[g] ? pwdata_i[8*g +: 8]
                                                 : cnt_r[8*g +: 8]; // RULE_01
        end
    endgenerate

    always_comb begin
        rd_val  = 32'h00000000;
        err_val = 1'b0;
        if (paddr_i == smt_pkg::OFS_CTRL0) begin
            rd_val[7:0] = ctrl_r;
        end else if (paddr_i == smt_pkg::OFS_CTRL1) begin
            rd_val[7:0] = run_r;
        end else if (paddr_i == smt_pkg::OFS_STAT) begin
            rd_val[smt_pkg::STAT_RUNST] = run_status_r; // RULE_14
            rd_val[smt_pkg::STAT_WIN]   = run_status_r & win_n; // RULE_12
            rd_val[smt_pkg::STAT_SIG]   = run_status_r & sig_n; // RULE_13
        end else if (paddr_i == smt_pkg::OFS_CLKSEL) begin
            rd_val[2:0] = clk_src_r;
        end else if (paddr_i == smt_pkg::OFS_COUNT) begin
            rd_val[23:0] = cnt_r; // RULE_01
        end else if (paddr_i == smt_pkg::OFS_PERIOD) begin
            rd_val[23:0] = per_r;
        end else if (paddr_i == smt_pkg::OFS_PWLAT) begin
            rd_val[23:0] = pw_r;
        end else if (paddr_i == smt_pkg::OFS_PRLAT) begin
            rd_val[23:0] = pr_r;
        end else begin
            err_val = 1'b1;
        end
    end

    // One wait-free access phase: ready rises the cycle after setup
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else begin
            pready_o  <= rd_setup;
            pslverr_o <= rd_setup & err_val;
            if (rd_setup && !pwrite_i) begin
                prdata_o <= rd_val;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r    <= '0;
            clk_src_r <= 3'h0;
            per_r     <= smt_pkg::PERIOD_RST;
        end else if (wr) begin
            if (paddr_i == smt_pkg::OFS_CTRL0 && pstrb_i[0]) begin
                ctrl_r <= {pwdata_i[7], 1'b0, pwdata_i[5:0]};
            end
            if (paddr_i == smt_pkg::OFS_CLKSEL && pstrb_i[0]) begin
                clk_src_r <= pwdata_i[2:0]; // RULE_03
            end
            if (paddr_i == smt_pkg::OFS_PERIOD) begin
                per_r <= {pstrb_i[2] ? pwdata_i[23:16] : per_r[23:16],
                          pstrb_i[1] ? pwdata_i[15:8]  : per_r[15:8],
                          pstrb_i[0] ? pwdata_i[7:0]   : per_r[7:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Run request
    // ------------------------------------------------------------
    // A software write wins over the completion clear in the same cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_r <= '0;
        end else if (wr_ctrl1) begin
            run_r <= {pwdata_i[7:5], 1'b0, pwdata_i[3:0]};
        end else if (!ctrl_r.en) begin
            run_r.run <= 1'b0; // RULE_21
        end else if (run_status_r && done_t && !run_r.rep) begin
            run_r.run <= 1'b0; // RULE_15
        end
    end

    // ------------------------------------------------------------
    // Counter and latches
    // ------------------------------------------------------------
    always_comb begin
        if (!ctrl_r.en || sw_clr) begin
            cnt_nxt = 24'h000000; // RULE_06 RULE_21
        end else if (wr_cnt) begin
            cnt_nxt = cnt_wr & mask; // RULE_07
        end else if (rs_hit) begin
            cnt_nxt = smt_pkg::CNT_ONE;
        end else if (match_ev) begin
            cnt_nxt = ctrl_r.halt ? cnt_r : 24'h000000; // RULE_05 RULE_22
        end else if (step) begin
            cnt_nxt = (cnt_r + 24'h000001) & mask; // RULE_18
        end else begin
            cnt_nxt = cnt_r; // RULE_23
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 24'h000000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pw_r <= 24'h000000;
            pr_r <= 24'h000000;
        end else begin
            if (pw_hit || sw_pwup) begin
                pw_r <= cnt_r; // RULE_08
            end
            if (pr_hit || sw_prup) begin
                pr_r <= cnt_r; // RULE_09
            end
        end
    end

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    // Without halt the match flag is a pulse; with halt it is held
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            period_match_o  <= 1'b0;
            pw_acq_o        <= 1'b0;
            pr_acq_o        <= 1'b0;
            clock_request_o <= 1'b0;
        end else begin
            if (match_ev) begin
                period_match_o <= 1'b1; // RULE_05
            end else if (!ctrl_r.en || sw_clr || (wr_cnt && !run_r.run)) begin
                period_match_o <= 1'b0; // RULE_10
            end else if (!ctrl_r.halt) begin
                period_match_o <= 1'b0;
            end
            pw_acq_o        <= pw_hit; // RULE_20
            pr_acq_o        <= pr_hit; // RULE_20
            clock_request_o <= ctrl_r.en; // RULE_21
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_clear;
        sw_clr |=> (cnt_r == 24'h000000);
    endproperty
    a_clear: assert property (p_clear) else $error("clear missed"); // RULE_06

    property p_roll;
        match_ev && !ctrl_r.halt && !sw_clr && !wr_cnt && !rs_hit
            |=> (cnt_r == 24'h000000) && period_match_o;
    endproperty
    a_roll: assert property (p_roll) else $error("no rollover"); // RULE_05

    property p_halt;
        match_ev && ctrl_r.halt && ctrl_r.en && !sw_clr && !wr_cnt
            && !rs_hit |=> $stable(cnt_r) && period_match_o;
    endproperty
    a_halt: assert property (p_halt) else $error("halt lost"); // RULE_22

    property p_hold;
        period_match_o && ctrl_r.halt && ctrl_r.en && !sw_clr
            && !wr_cnt |=> period_match_o;
    endproperty
    a_hold: assert property (p_hold) else $error("match dropped"); // RULE_10

    property p_pw;
        (pw_hit || sw_pwup) |=> (pw_r == $past(cnt_r))
            && (pw_acq_o == $past(pw_hit));
    endproperty
    a_pw: assert property (p_pw) else $error("width latch wrong"); // RULE_08

    property p_pr;
        (pr_hit || sw_prup) |=> (pr_r == $past(cnt_r));
    endproperty
    a_pr: assert property (p_pr) else $error("period latch wrong"); // RULE_09

    property p_single;
        run_status_r && done_t && !run_r.rep && !wr_ctrl1 |=> !run_r.run;
    endproperty
    a_single: assert property (p_single) else $error("run kept"); // RULE_15

    property p_off;
        !ctrl_r.en && !wr |=> (cnt_r == 24'h000000) && !run_status_r
            ##1 !clock_request_o;
    endproperty
    a_off: assert property (p_off) else $error("disable leak"); // RULE_21

    property p_rsv;
        reserved && ctrl_r.en && !wr |=> $stable(cnt_r) && $stable(pw_r)
            && $stable(pr_r) ##1 !pw_acq_o && !pr_acq_o;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved moved"); // RULE_23

    property p_acq;
        pr_hit |=> pr_acq_o;
    endproperty
    a_acq: assert property (p_acq) else $error("no acq event"); // RULE_20

    c_match:  cover property (match_ev && !ctrl_r.halt);
    c_gated:  cover property (pw_hit && run_r.mode == smt_pkg::M_GATED);
    c_single: cover property (run_r.run ##1 !run_r.run);
endmodule
`default_nettype wire

/* dv/smt_pin_model.sv */
/* Far-side pin model: measured signal and window lines.
   Assumes the bench requests levels; pins move only at clock edges. */
`timescale 1ns/10ps
`default_nettype none
module smt_pin_model (
    input  wire logic clk_i,
    input  wire logic sig_req_i,
    input  wire logic win_req_i,
    output logic      sig_o,
    output logic      win_o
);
    // Registered so a pin never changes in the sampling step
    always_ff @(posedge clk_i) begin
        sig_o <= sig_req_i;
        win_o <= win_req_i;
    end
endmodule
`default_nettype wire

/* dv/signal_measurement_timer_tb_top.sv */
/* Self-checking bench of the measurement timer over APB.
   Assumes the register map and field layout of the shared package. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module signal_measurement_timer_tb_top;
    logic        clk, rst, psel, pen, pwr, sig, win, sq, wq, er;
    logic [7:0]  pa;
    logic [31:0] pwd, prd, rd;
    logic        prdy, perr, pm, pwa, pra, creq, s_pw, s_pm, s_pr;
    int          n_errors, tests_run;
    smt_core dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
        .pstrb_i(4'hF), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
        .measured_signal_i(sig), .window_input_i(win),
        .fast_internal_osc_i(1'h0), .slow_internal_osc_i(1'h0),
        .medium_internal_osc_i(1'h0), .period_match_o(pm),
        .pw_acq_o(pwa), .pr_acq_o(pra), .clock_request_o(creq));
    smt_pin_model pins (.clk_i(clk), .sig_req_i(sq), .win_req_i(wq),
        .sig_o(sig), .win_o(win));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pwa) s_pw <= 1;
        if (pm) s_pm <= 1;
        if (pra) s_pr <= 1;
    end
    // -----------------------------------------
    // APB master and closing
    // -----------------------------------------
    task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwr, pa, pwd} <= {1'h1, w, a, d};
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'h1);
        rd = prd;
        er = perr;
        {psel, pen} <= 2'h0;
    endtask
    task summarize;
        $display("Errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end
    // -----------------------------------------
    // Tests
    // -----------------------------------------
    initial begin
        {psel, pen, pwr, sq, wq, s_pw, s_pm, s_pr, pa, pwd} = '0;
        {n_errors, tests_run} = '0;
        rst = 1;
        repeat (20) @(posedge clk);
        rst <= 0;
        xf(0, smt_pkg::OFS_PERIOD, 0); `CHK(rd, 32'h00FFFFFF)
        xf(0, 8'h20, 0); `CHK(er, 1'h1)
        // Counter touched only while stopped
        xf(1, smt_pkg::OFS_CTRL0, 32'h80);
        xf(1, smt_pkg::OFS_COUNT, 32'h123456);
        `CHK(creq, 1'h1)
        xf(0, smt_pkg::OFS_COUNT, 0); `CHK(rd, 32'h00123456)
        xf(1, smt_pkg::OFS_STAT, 32'h6);
        xf(0, smt_pkg::OFS_PWLAT, 0); `CHK(rd, 32'h00123456)
        xf(0, smt_pkg::OFS_PRLAT, 0); `CHK(rd, 32'h00123456)
        xf(1, smt_pkg::OFS_STAT, 32'h1);
        xf(0, smt_pkg::OFS_COUNT, 0); `CHK(rd, 32'h0)
        xf(1, smt_pkg::OFS_CTRL1, 32'h20);
        xf(1, smt_pkg::OFS_COUNT, 32'hABCDEF);
        xf(0, smt_pkg::OFS_COUNT, 0); `CHK(rd, 32'h0000CDEF)
        $display("Test registers done");
        xf(1, smt_pkg::OFS_CTRL1, 0);
        xf(1, smt_pkg::OFS_STAT, 32'h1);
        xf(1, smt_pkg::OFS_PERIOD, 32'h5);
        xf(1, smt_pkg::OFS_CTRL0, 32'hA0); `CHK(creq, 1'h1)
        xf(1, smt_pkg::OFS_CTRL1, 32'h80);
        repeat (30) @(posedge clk);
        xf(0, smt_pkg::OFS_COUNT, 0); `CHK(rd, 32'h5)
        `CHK(pm, 1'h1)
        xf(1, smt_pkg::OFS_CTRL1, 0);
        xf(1, smt_pkg::OFS_STAT, 32'h1);
        xf(0, smt_pkg::OFS_COUNT, 0); `CHK(pm, 1'h0)
        xf(1, smt_pkg::OFS_PERIOD, 32'h3);
        xf(1, smt_pkg::OFS_CTRL0, 32'h80);
        xf(1, smt_pkg::OFS_CTRL1, 32'h80);
        repeat (30) @(posedge clk);
        `CHK(s_pm, 1'h1)
        xf(0, smt_pkg::OFS_COUNT, 0); `CHK(rd <= 32'h3, 1'h1)
        $display("Test halt and rollover done");
        xf(1, smt_pkg::OFS_CTRL1, 0);
        xf(1, smt_pkg::OFS_PERIOD, 32'hFFFFFF);
        xf(1, smt_pkg::OFS_STAT, 32'h1);
        xf(1, smt_pkg::OFS_CTRL1, 32'h81);
        repeat (5) @(posedge clk);
        xf(0, smt_pkg::OFS_STAT, 0); `CHK(rd[7:5], 3'h4)
        sq <= 1;
        repeat (6) @(posedge clk);
        xf(0, smt_pkg::OFS_STAT, 0); `CHK(rd[5], 1'h1)
        sq <= 0;
        repeat (10) @(posedge clk);
        `CHK(s_pw, 1'h1)
        xf(0, smt_pkg::OFS_PWLAT, 0); `CHK(rd > 6 && rd < 16, 1'h1)
        xf(0, smt_pkg::OFS_CTRL1, 0); `CHK(rd[7], 1'h0)
        xf(1, smt_pkg::OFS_CTRL1, 32'hC4);
        wq <= 1;
        repeat (8) @(posedge clk);
        `CHK(s_pr, 1'h1)
        xf(1, smt_pkg::OFS_CTRL1, 0);
        $display("Test gated timer done");
        xf(1, smt_pkg::OFS_COUNT, 32'h77);
        xf(1, smt_pkg::OFS_CTRL1, 32'h8B);
        repeat (10) @(posedge clk);
        xf(0, smt_pkg::OFS_COUNT, 0); `CHK(rd, 32'h77)
        xf(1, smt_pkg::OFS_CTRL0, 0);
        xf(0, smt_pkg::OFS_COUNT, 0); `CHK(rd, 32'h0)
        `CHK(creq, 1'h0)
        $display("Test reserved and disable done");
        summarize();
    end
endmodule
`default_nettype wire
